/* common/wwd_defines.svh */
// register offsets, field positions, reset values and timing counts of the window watchdog
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define WWD_IDX_CONTROL       2'h0
`define WWD_IDX_WINDOW        2'h1
`define WWD_ADDR_CONTROL      12'h000
`define WWD_ADDR_WINDOW       12'h004
`define WWD_ADDR_STATUS       12'h008
`define WWD_ACT_BIT           7
`define WWD_TOP_BIT           6
`define WWD_COUNT_RESET       7'h7F
`define WWD_WINDOW_RESET      7'h7F
`define WWD_PRESCALE_CYCLES   12288
`define WWD_PRESCALE_LAST     14'h2FFF
`define WWD_RST_PULSE_CYCLES  4'h8

`endif

/* common/wwd_pkg.sv */
// types shared by the window watchdog
package wwd_pkg;

	typedef enum logic [1:0] {
		WWD_RUN   = 2'h1,
		WWD_RESET = 2'h2
	} wwd_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} wwd_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} wwd_apb_rsp_t;

	typedef struct packed {
		wwd_state_t  state;
		logic        act;
		logic [6:0]  count;
		logic [6:0]  window;
		logic [13:0] presc;
		logic [3:0]  rst_cnt;
		logic [1:0]  cause;
		logic [31:0] prdata;
		logic        pslverr;
	} wwd_state_s_t;

endpackage

/* verilog/wwd_window_watchdog.sv */
// window watchdog with apb register access and system reset request
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defines.svh"

// Overview of operation
// - activation flag set by write, cleared by reset
// - flag high enables reset, low blocks it unless the hardware option is set
// - count steps every 12288 cycles, free prescaler
// - reset when count falls from 0x40
// - count in bits 6:0, resets to 0x7F
// - hardware option forces watchdog permanently enabled
// - window limit bits 6:0, bit 7 zero
// - reset on reload above window limit
// - counter decrements even while disabled
// - halt request resets when option selected
module wwd_window_watchdog (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire wwd_pkg::wwd_apb_req_t apb_req,
	output      wwd_pkg::wwd_apb_rsp_t apb_rsp,
	input  wire logic                  hw_watchdog_option,
	input  wire logic                  halt_reset_option,
	input  wire logic                  halt_request,
	output      logic                  halt_grant,
	output      logic                  system_reset_req
);

	wwd_pkg::wwd_state_s_t s_q;
	wwd_pkg::wwd_state_s_t s_d;

	logic       enabled;
	logic       wr_access;
	logic       rd_setup;
	logic       wr_control;
	logic       wr_window;
	logic       step;
	logic [6:0] count_next;
	logic       expire;
	logic       early_reload;
	logic       halt_reset;

	function automatic logic addr_hit(input logic [11:0] addr);
		addr_hit = (addr == `WWD_ADDR_CONTROL) || (addr == `WWD_ADDR_WINDOW)
			|| (addr == `WWD_ADDR_STATUS);
	endfunction

	assign enabled      = s_q.act | hw_watchdog_option;
	assign wr_access    = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_setup     = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
	assign wr_control   = wr_access && apb_req.paddr == `WWD_ADDR_CONTROL;
	assign wr_window    = wr_access && apb_req.paddr == `WWD_ADDR_WINDOW;
	assign step         = s_q.presc == `WWD_PRESCALE_LAST;
	assign count_next   = step ? s_q.count - 7'h01 : s_q.count;
	// top bit falling on a tick counts as expiry; software clearing it is checked separately in the state logic
	assign expire       = s_q.count[`WWD_TOP_BIT] & ~count_next[`WWD_TOP_BIT];
	assign early_reload = wr_control && (s_q.count > s_q.window);
	assign halt_reset   = halt_request & halt_reset_option;

	// halt passes through only when no reset is to be issued instead
	assign halt_grant       = halt_request & ~(enabled & halt_reset_option);
	assign system_reset_req = s_q.state == wwd_pkg::WWD_RESET;

	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = s_q.pslverr;
	assign apb_rsp.prdata  = s_q.prdata;

	always_comb begin
		s_d         = s_q;
		s_d.pslverr = 1'b0;
		// prescaler phase is never disturbed by register writes
		s_d.presc   = step ? 14'h0000 : s_q.presc + 14'h0001;
		s_d.count   = count_next;
		if (wr_control) begin
			s_d.count = apb_req.pwdata[6:0];
			if (apb_req.pwdata[`WWD_ACT_BIT]) begin
				s_d.act = 1'b1;
			end
		end
		if (wr_window) begin
			s_d.window = apb_req.pwdata[6:0];
		end
		// read data and error are latched in setup so they stand through the access phase
		if (rd_setup) begin
			unique case (apb_req.paddr)
				`WWD_ADDR_CONTROL: s_d.prdata = {24'h000000, s_q.act, s_q.count};
				`WWD_ADDR_WINDOW:  s_d.prdata = {25'h0000000, s_q.window};
				`WWD_ADDR_STATUS:  s_d.prdata = {28'h0000000, enabled, 1'b0, s_q.cause};
				default:           s_d.prdata = 32'h00000000;
			endcase
		end
		if ((apb_req.psel & ~apb_req.penable) && !addr_hit(apb_req.paddr)) begin
			s_d.pslverr = 1'b1;
		end
		unique case (s_q.state)
			wwd_pkg::WWD_RUN: begin
				// a control write loads the counter, so the tick-based expiry is void then
				if (enabled && ((expire && !wr_control) || early_reload
					|| (wr_control && !apb_req.pwdata[`WWD_TOP_BIT])
					|| halt_reset)) begin
					s_d.state   = wwd_pkg::WWD_RESET;
					s_d.rst_cnt = `WWD_RST_PULSE_CYCLES;
					s_d.cause   = early_reload ? 2'h2 : (halt_reset ? 2'h3 : 2'h1);
				end
			end
			wwd_pkg::WWD_RESET: begin
				// held until the system reset returns through resetn
				if (s_q.rst_cnt != 4'h0) begin
					s_d.rst_cnt = s_q.rst_cnt - 4'h1;
				end
			end
			default: s_d.state = wwd_pkg::WWD_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q.state   <= wwd_pkg::WWD_RUN;
			s_q.act     <= 1'b0;
			s_q.count   <= `WWD_COUNT_RESET;
			s_q.window  <= `WWD_WINDOW_RESET;
			s_q.presc   <= 14'h0000;
			s_q.rst_cnt <= 4'h0;
			s_q.cause   <= 2'h0;
			s_q.prdata  <= 32'h00000000;
			s_q.pslverr <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule
`default_nettype wire

/* dv/wwd_window_watchdog_chk.sv */
// port assertions for the window watchdog
`timescale 1ns/1ps
`default_nettype none
module wwd_chk (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire wwd_pkg::wwd_apb_req_t apb_req,
	input wire wwd_pkg::wwd_apb_rsp_t apb_rsp,
	input wire logic                  hw_watchdog_option,
	input wire logic                  halt_reset_option,
	input wire logic                  halt_request,
	input wire logic                  halt_grant,
	input wire logic                  system_reset_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
	wire logic wr0 = apb_req.psel & apb_req.penable & apb_req.pwrite & (apb_req.paddr == 12'h000);
	a_req_sticky: assert property (system_reset_req |=> system_reset_req) else $error("req dropped");
	a_grant_cause: assert property (halt_grant |-> halt_request) else $error("stray grant");
	a_hw_halt: assert property (hw_watchdog_option && halt_reset_option && halt_request
		|-> !halt_grant ##[1:2] system_reset_req) else $error("halt kept");
	a_sw_reset: assert property (hw_watchdog_option && wr0 && !apb_req.pwdata[6]
		|-> ##[1:2] system_reset_req) else $error("no top bit reset");
	a_ready_high: assert property (apb_rsp.pready) else $error("wait state");
	a_win_read: assert property (acc && apb_req.paddr == 12'h004
		|-> apb_rsp.prdata[31:7] == 25'h0) else $error("window high bits");
	a_ctl_read: assert property (acc && apb_req.paddr == 12'h000
		|-> apb_rsp.prdata[31:8] == 24'h0) else $error("control high bits");
	a_bad_addr: assert property (acc && apb_req.paddr > 12'h008 |-> apb_rsp.pslverr)
		else $error("no slave error");
endmodule
bind wwd_window_watchdog wwd_chk u_chk (.clk, .resetn, .apb_req, .apb_rsp, .hw_watchdog_option,
	.halt_reset_option, .halt_request, .halt_grant, .system_reset_req);
`default_nettype wire

/* dv/wwd_window_watchdog_tb.sv */
// self-checking bench for the window watchdog
`timescale 1ns/1ps
`default_nettype none
module wwd_window_watchdog_tb;
	logic                  clk = 1'b0;
	logic                  resetn = 1'b0;
	wwd_pkg::wwd_apb_req_t req = '0;
	wwd_pkg::wwd_apb_rsp_t rsp;
	logic                  hw = 1'b0, hro = 1'b0, hreq = 1'b0, grant, sreq;
	logic [31:0]           rd;
	logic                  err;
	logic [6:0]            w;
	int                    miscompares = 0, checks_done = 0;
	integer                seed = 32'h9CBCA74B;
	always #5 clk = ~clk;
	wwd_window_watchdog dut (.clk, .resetn, .apb_req(req), .apb_rsp(rsp),
		.hw_watchdog_option(hw), .halt_reset_option(hro), .halt_request(hreq),
		.halt_grant(grant), .system_reset_req(sreq));
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// read data and error are taken at the access edge, before the design updates
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk) req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk) req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 64);
		if (rsp.pready !== 1'b1) begin
			miscompares++;
			complete_run;
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task rst;
		@(posedge clk) resetn <= 1'b0;
		hw <= 1'b0;
		hreq <= 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
	endtask
	task wait_req(input int lim);
		for (int n = 0; n < lim && sreq !== 1'b1; n++) @(posedge clk);
		chk(sreq, 1);
		if (sreq !== 1'b1)
			complete_run;
	endtask
	initial begin
		rst;
		xfer(0, 12'h000, 0);
		chk(rd, 32'h7F);
		xfer(0, 12'h004, 0);
		chk(rd, 32'h7F);
		w = 7'($random(seed));
		xfer(1, 12'h004, {24'h0, 1'b1, w});
		xfer(0, 12'h004, 0);
		chk(rd, {25'h0, w});
		xfer(0, 12'h00C, 0);
		chk(err, 1);
		// disabled counter still steps and may clear its top bit silently
		xfer(1, 12'h000, 32'h40);
		repeat (12300) @(posedge clk);
		xfer(0, 12'h000, 0);
		chk(rd == 32'h3F || rd == 32'h3E, 1);
		chk(sreq, 0);
		@(posedge clk) hreq <= 1'b1;
		@(negedge clk) chk(grant, 1);
		xfer(1, 12'h000, 32'hC0);
		chk(sreq, 0);
		wait_req(12400);
		rst;
		xfer(1, 12'h000, 32'hFF);
		xfer(1, 12'h000, 32'h7F);
		xfer(0, 12'h000, 0);
		chk(rd[7], 1);
		xfer(1, 12'h004, 32'h50);
		chk(sreq, 0);
		xfer(1, 12'h000, 32'hFF);
		wait_req(4);
		rst;
		@(posedge clk) hw <= 1'b1;
		xfer(1, 12'h000, 32'h3F);
		wait_req(4);
		rst;
		@(posedge clk) hw <= 1'b1;
		xfer(1, 12'h000, 32'hFF);
		chk(sreq, 0);
		hro <= 1'b1;
		hreq <= 1'b1;
		@(negedge clk) chk(grant, 0);
		wait_req(4);
		complete_run;
	end
endmodule
`default_nettype wire
